/* File: hw/flc_top.sv */
// Flash and torch LED control: register bank, trigger routing, throttling.
// Assumes the serial front end delivers decoded byte reads and writes,
// and a battery level in mV from a converter on this clock.
//
// Function
// [R1] Torch code bits 3:0 sets total torch current, 16 steps of 23.436mA.
// [R2] Each channel carries half of the total torch current.
// [R3] Four-bit code selects torch safety timeout from 262ms to 15.728s.
// [R4] Bit 6 set switches the torch safety timer off.
// [R5] Torch timer bit 7: 0 one-shot, 1 run for full timer.
// [R6] Flash timeout code gives 62.5ms to 1000ms in 62.5ms steps.
// [R7] Flash timer bit 7: 0 one-shot, 1 run for full timer.
// [R8] Two-bit torch source per channel: off, flash pin, torch pin, serial.
// [R9] Two-bit flash source per channel: off, flash pin, torch pin, serial.
// [R10] Flash beats torch; torch starts only after flash completes.
// [R11] Bit 7 of battery setting enables throttling.
// [R12] Bits 6:2 set threshold from 2.4V in 33mV steps, capped 3.4V.
// [R13] Bits 1:0 set 100-300mV hysteresis; code 3 never restores current.
// [R14] Bits 2:0 set falling mask time 256us to 2048us.
// [R15] Bits 5:3 set rising mask time 256us to 2048us.
// [R16] Per channel, record lowest current reached and torch or flash kind.
// [R17] Expired safety timer ends flash or torch despite a held trigger.
// [R18] Throttle lowers current after falling mask, restores after rising mask.
`timescale 1ns/100ps
module flc_top #(
	parameter int TICK_CYCLES = flc_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rd_valid,
	input wire logic flash_trigger_pin,
	input wire logic torch_trigger_pin,
	input wire logic [4:0] flash_code_a,
	input wire logic [4:0] flash_code_b,
	input wire logic [11:0] batt_mv,
	output logic chan_a_flash_on,
	output logic chan_a_torch_on,
	output logic [5:0] chan_a_level,
	output logic chan_b_flash_on,
	output logic chan_b_torch_on,
	output logic [5:0] chan_b_level,
	output logic battery_throttle
);
	typedef struct packed {
		logic [3:0] torch_current_code;
		logic [3:0] torch_timeout_sel;
		logic torch_timeout_off;
		logic torch_timeout_style;
		logic [3:0] flash_timeout_sel;
		logic flash_timeout_style;
		logic [1:0] torch_src_chan_a;
		logic [1:0] torch_src_chan_b;
		logic [1:0] flash_src_chan_a;
		logic [1:0] flash_src_chan_b;
		logic lowbat_throttle_on;
		logic [4:0] lowbat_threshold;
		logic [1:0] lowbat_hysteresis;
		logic [2:0] lowbat_rise_mask;
		logic [2:0] lowbat_fall_mask;
		logic [5:0] chan_a_lowest_current;
		logic chan_a_event_kind;
		logic [5:0] chan_b_lowest_current;
		logic chan_b_event_kind;
		logic fpin_s1;
		logic fpin_s2;
		logic tpin_s1;
		logic tpin_s2;
		logic [11:0] pre_cnt;
		logic tick;
		logic [7:0] step_cnt;
		logic step;
		logic event_a;
		logic event_b;
		logic [5:0] level_a;
		logic [5:0] level_b;
		logic [7:0] rdata;
		logic rd_valid;
	} flc_top_s;

	flc_top_s s_r;
	flc_top_s s_nxt;
	logic fl_a;
	logic fl_b;
	logic to_a;
	logic to_b;
	logic throttle_w;
	logic [5:0] nom_a;
	logic [5:0] nom_b;

	// ==========================================================
	// Helpers

	// [R8] Source decode
	// [R9] Source decode
	function automatic logic src_active(input logic [1:0] sel, input logic fpin,
			input logic tpin);
		logic v;
		v = 1'b0;
		unique case (sel)
			flc_pkg::SRC_OFF: v = 1'b0;
			flc_pkg::SRC_FLASH_PIN: v = fpin;
			flc_pkg::SRC_TORCH_PIN: v = tpin;
			flc_pkg::SRC_SERIAL: v = 1'b1;
		endcase
		return v;
	endfunction

	// Level in 11.72mA units; flash step is two units, torch step one
	function automatic logic [5:0] nominal(input logic flash, input logic [4:0] fcode,
			input logic [3:0] tcode);
		logic [5:0] v;
		// [R2] Half of total per channel
		v = flash ? {fcode, 1'b1} : {2'h0, tcode};
		return v;
	endfunction

	// ==========================================================
	// Channels and detector
	flc_led_chan u_chan_a (
		.clk(clk),
		.resetn(resetn),
		.tick(s_r.tick),
		.flash_req(src_active(s_r.flash_src_chan_a, s_r.fpin_s2, s_r.tpin_s2)),
		.torch_req(src_active(s_r.torch_src_chan_a, s_r.fpin_s2, s_r.tpin_s2)),
		.flash_style(s_r.flash_timeout_style),
		.torch_style(s_r.torch_timeout_style),
		.torch_timer_off(s_r.torch_timeout_off),
		.flash_limit(flc_pkg::flash_limit_us(s_r.flash_timeout_sel)),
		.torch_limit(flc_pkg::torch_limit_us(s_r.torch_timeout_sel)),
		.flash_on(fl_a),
		.torch_on(to_a)
	);

	flc_led_chan u_chan_b (
		.clk(clk),
		.resetn(resetn),
		.tick(s_r.tick),
		.flash_req(src_active(s_r.flash_src_chan_b, s_r.fpin_s2, s_r.tpin_s2)),
		.torch_req(src_active(s_r.torch_src_chan_b, s_r.fpin_s2, s_r.tpin_s2)),
		.flash_style(s_r.flash_timeout_style),
		.torch_style(s_r.torch_timeout_style),
		.torch_timer_off(s_r.torch_timeout_off),
		// [R6] Flash timeout
		.flash_limit(flc_pkg::flash_limit_us(s_r.flash_timeout_sel)),
		// [R3] Torch timeout
		.torch_limit(flc_pkg::torch_limit_us(s_r.torch_timeout_sel)),
		.flash_on(fl_b),
		.torch_on(to_b)
	);

	flc_lowbat u_lowbat (
		.clk(clk),
		.resetn(resetn),
		.tick(s_r.tick),
		.enable(s_r.lowbat_throttle_on),
		.threshold(s_r.lowbat_threshold),
		.hysteresis(s_r.lowbat_hysteresis),
		.fall_sel(s_r.lowbat_fall_mask),
		.rise_sel(s_r.lowbat_rise_mask),
		.batt_mv(batt_mv),
		.throttle(throttle_w)
	);

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		// Pins pass two flops before use
		s_nxt.fpin_s1 = flash_trigger_pin;
		s_nxt.fpin_s2 = s_r.fpin_s1;
		s_nxt.tpin_s1 = torch_trigger_pin;
		s_nxt.tpin_s2 = s_r.tpin_s1;

		// Microsecond tick and slower throttle step
		s_nxt.tick = 1'b0;
		s_nxt.step = 1'b0;
		if (s_r.pre_cnt >= 12'(TICK_CYCLES - 1)) begin
			s_nxt.pre_cnt = 12'h0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.pre_cnt = s_r.pre_cnt + 12'h1;
		end
		if (s_r.tick) begin
			if (s_r.step_cnt >= flc_pkg::STEP_DOWN_US) begin
				s_nxt.step_cnt = 8'h0;
				s_nxt.step = 1'b1;
			end else begin
				s_nxt.step_cnt = s_r.step_cnt + 8'h1;
			end
		end

		// Register writes; reserved bits are dropped
		if (reg_wr_en) begin
			unique case (reg_addr)
				flc_pkg::ADDR_TORCH_CUR: begin
					// [R1] Torch current code
					s_nxt.torch_current_code = reg_wdata[flc_pkg::TORCH_CODE_LSB +: 4];
				end
				flc_pkg::ADDR_TORCH_TIMEOUT_SETTING: begin
					s_nxt.torch_timeout_sel = reg_wdata[flc_pkg::TMR_SEL_LSB +: 4];
					s_nxt.torch_timeout_off = reg_wdata[flc_pkg::TORCH_OFF_BIT];
					s_nxt.torch_timeout_style = reg_wdata[flc_pkg::TMR_STYLE_BIT];
				end
				flc_pkg::ADDR_FLASH_TIMEOUT_SETTING: begin
					s_nxt.flash_timeout_sel = reg_wdata[flc_pkg::TMR_SEL_LSB +: 4];
					s_nxt.flash_timeout_style = reg_wdata[flc_pkg::TMR_STYLE_BIT];
				end
				flc_pkg::ADDR_TRIG_SEL: begin
					s_nxt.torch_src_chan_b = reg_wdata[flc_pkg::TORCH_SRC_B_LSB +: 2];
					s_nxt.torch_src_chan_a = reg_wdata[flc_pkg::TORCH_SRC_A_LSB +: 2];
					s_nxt.flash_src_chan_b = reg_wdata[flc_pkg::FLASH_SRC_B_LSB +: 2];
					s_nxt.flash_src_chan_a = reg_wdata[flc_pkg::FLASH_SRC_A_LSB +: 2];
				end
				flc_pkg::ADDR_LOWBAT_V: begin
					s_nxt.lowbat_hysteresis = reg_wdata[flc_pkg::HYS_LSB +: 2];
					s_nxt.lowbat_threshold = reg_wdata[flc_pkg::THRESH_LSB +: 5];
					s_nxt.lowbat_throttle_on = reg_wdata[flc_pkg::THROTTLE_ON_BIT];
				end
				flc_pkg::ADDR_LOWBAT_T: begin
					s_nxt.lowbat_fall_mask = reg_wdata[flc_pkg::FALL_MASK_LSB +: 3];
					s_nxt.lowbat_rise_mask = reg_wdata[flc_pkg::RISE_MASK_LSB +: 3];
				end
				flc_pkg::ADDR_STAT_A: begin
					s_nxt.chan_a_lowest_current = reg_wdata[flc_pkg::STAT_LEVEL_LSB +: 6];
					s_nxt.chan_a_event_kind = reg_wdata[flc_pkg::STAT_KIND_BIT];
				end
				flc_pkg::ADDR_STAT_B: begin
					s_nxt.chan_b_lowest_current = reg_wdata[flc_pkg::STAT_LEVEL_LSB +: 6];
					s_nxt.chan_b_event_kind = reg_wdata[flc_pkg::STAT_KIND_BIT];
				end
				default: begin
				end
			endcase
		end

		// Channel levels; a throttle step lowers one unit down to zero
		nom_a = nominal(fl_a, flash_code_a, s_r.torch_current_code);
		nom_b = nominal(fl_b, flash_code_b, s_r.torch_current_code);
		s_nxt.event_a = throttle_w && (fl_a || to_a);
		s_nxt.event_b = throttle_w && (fl_b || to_b);
		if (!s_nxt.event_a) begin
			s_nxt.level_a = nom_a;
		end else if (!s_r.event_a) begin
			s_nxt.level_a = nom_a;
		end else if (s_r.step && s_r.level_a != 6'h0) begin
			s_nxt.level_a = s_r.level_a - 6'h1;
		end
		if (!s_nxt.event_b) begin
			s_nxt.level_b = nom_b;
		end else if (!s_r.event_b) begin
			s_nxt.level_b = nom_b;
		end else if (s_r.step && s_r.level_b != 6'h0) begin
			s_nxt.level_b = s_r.level_b - 6'h1;
		end

		// [R16] Record lowest level and kind; hardware beats a write
		if (s_nxt.event_a && (!s_r.event_a || s_nxt.level_a < s_r.chan_a_lowest_current)) begin
			s_nxt.chan_a_lowest_current = s_nxt.level_a;
			s_nxt.chan_a_event_kind = fl_a;
		end
		if (s_nxt.event_b && (!s_r.event_b || s_nxt.level_b < s_r.chan_b_lowest_current)) begin
			s_nxt.chan_b_lowest_current = s_nxt.level_b;
			s_nxt.chan_b_event_kind = fl_b;
		end

		// Register reads, one cycle later; unmapped reads give zero
		s_nxt.rd_valid = reg_rd_en;
		s_nxt.rdata = 8'h00;
		if (reg_rd_en) begin
			unique case (reg_addr)
				flc_pkg::ADDR_TORCH_CUR: s_nxt.rdata = {4'h0, s_r.torch_current_code};
				flc_pkg::ADDR_TORCH_TIMEOUT_SETTING: s_nxt.rdata = {s_r.torch_timeout_style,
						s_r.torch_timeout_off, 2'h0, s_r.torch_timeout_sel};
				flc_pkg::ADDR_FLASH_TIMEOUT_SETTING: s_nxt.rdata = {s_r.flash_timeout_style, 3'h0,
						s_r.flash_timeout_sel};
				flc_pkg::ADDR_TRIG_SEL: s_nxt.rdata = {s_r.flash_src_chan_a,
						s_r.flash_src_chan_b, s_r.torch_src_chan_a, s_r.torch_src_chan_b};
				flc_pkg::ADDR_LOWBAT_V: s_nxt.rdata = {s_r.lowbat_throttle_on,
						s_r.lowbat_threshold, s_r.lowbat_hysteresis};
				flc_pkg::ADDR_LOWBAT_T: s_nxt.rdata = {2'h0, s_r.lowbat_rise_mask,
						s_r.lowbat_fall_mask};
				flc_pkg::ADDR_STAT_A: s_nxt.rdata = {s_r.chan_a_event_kind, 1'b0,
						s_r.chan_a_lowest_current};
				flc_pkg::ADDR_STAT_B: s_nxt.rdata = {s_r.chan_b_event_kind, 1'b0,
						s_r.chan_b_lowest_current};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	always_ff @(posedge clk) begin
		if (!resetn) begin
			chan_a_flash_on <= 1'b0;
			chan_a_torch_on <= 1'b0;
			chan_b_flash_on <= 1'b0;
			chan_b_torch_on <= 1'b0;
			battery_throttle <= 1'b0;
		end else begin
			chan_a_flash_on <= fl_a;
			chan_a_torch_on <= to_a;
			chan_b_flash_on <= fl_b;
			chan_b_torch_on <= to_b;
			battery_throttle <= throttle_w;
		end
	end

	assign chan_a_level = s_r.level_a;
	assign chan_b_level = s_r.level_b;
	assign reg_rdata = s_r.rdata;
	assign reg_rd_valid = s_r.rd_valid;
endmodule

/* File: include/flc_pkg.sv */
// Shared constants for the flash and torch LED control block.
// Assumes a 250 MHz core clock and a byte-wide register port.
package flc_pkg;

	// ==========================================================
	// Clock and time base
	localparam int CLK_MHZ = 250;
	localparam int TICK_US = 1;
	localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_TORCH_CUR = 8'h02;
	localparam logic [7:0] ADDR_TORCH_TIMEOUT_SETTING = 8'h03;
	localparam logic [7:0] ADDR_FLASH_TIMEOUT_SETTING = 8'h04;
	localparam logic [7:0] ADDR_TRIG_SEL = 8'h05;
	localparam logic [7:0] ADDR_LOWBAT_V = 8'h06;
	localparam logic [7:0] ADDR_LOWBAT_T = 8'h07;
	localparam logic [7:0] ADDR_STAT_A = 8'h08;
	localparam logic [7:0] ADDR_STAT_B = 8'h09;

	// ==========================================================
	// Field positions
	localparam int TORCH_CODE_LSB = 0;
	localparam int TMR_SEL_LSB = 0;
	localparam int TORCH_OFF_BIT = 6;
	localparam int TMR_STYLE_BIT = 7;
	localparam int TORCH_SRC_B_LSB = 0;
	localparam int TORCH_SRC_A_LSB = 2;
	localparam int FLASH_SRC_B_LSB = 4;
	localparam int FLASH_SRC_A_LSB = 6;
	localparam int HYS_LSB = 0;
	localparam int THRESH_LSB = 2;
	localparam int THROTTLE_ON_BIT = 7;
	localparam int FALL_MASK_LSB = 0;
	localparam int RISE_MASK_LSB = 3;
	localparam int STAT_LEVEL_LSB = 0;
	localparam int STAT_KIND_BIT = 7;

	// ==========================================================
	// Reset values
	localparam logic [7:0] REG_RESET = 8'h00;

	// ==========================================================
	// Trigger source codes and the no-restore hysteresis code
	localparam logic [1:0] SRC_OFF = 2'h0;
	localparam logic [1:0] SRC_FLASH_PIN = 2'h1;
	localparam logic [1:0] SRC_TORCH_PIN = 2'h2;
	localparam logic [1:0] SRC_SERIAL = 2'h3;
	localparam logic [1:0] HYS_NONE = 2'h3;

	// ==========================================================
	// Timing and analog step sizes
	localparam logic [23:0] FLASH_STEP_US = 24'd62500;
	localparam logic [11:0] MASK_STEP_US = 12'd256;
	localparam logic [11:0] TH_BASE_MV = 12'd2400;
	localparam logic [11:0] TH_STEP_MV = 12'd33;
	localparam logic [11:0] TH_MAX_MV = 12'd3400;
	localparam logic [4:0] TH_SAT_CODE = 5'h1e;
	localparam logic [11:0] HYS_STEP_MV = 12'd100;
	localparam logic [7:0] STEP_DOWN_US = 8'hff;

	// Torch timeout in microseconds
	function automatic logic [23:0] torch_limit_us(input logic [3:0] sel);
		logic [23:0] v;
		v = 24'd262000;
		unique case (sel)
			4'h0: v = 24'd262000;
			4'h1: v = 24'd524000;
			4'h2: v = 24'd786000;
			4'h3: v = 24'd1048000;
			4'h4: v = 24'd1572000;
			4'h5: v = 24'd2096000;
			4'h6: v = 24'd2620000;
			4'h7: v = 24'd3144000;
			4'h8: v = 24'd4193000;
			4'h9: v = 24'd5242000;
			4'ha: v = 24'd6291000;
			4'hb: v = 24'd7340000;
			4'hc: v = 24'd9437000;
			4'hd: v = 24'd11534000;
			4'he: v = 24'd13631000;
			4'hf: v = 24'd15728000;
		endcase
		return v;
	endfunction

	function automatic logic [23:0] flash_limit_us(input logic [3:0] sel);
		return FLASH_STEP_US * ({20'h0, sel} + 24'h1);
	endfunction

	function automatic logic [11:0] mask_limit_us(input logic [2:0] sel);
		return MASK_STEP_US * ({9'h0, sel} + 12'h1);
	endfunction

	function automatic logic [11:0] thresh_mv(input logic [4:0] code);
		logic [11:0] v;
		v = TH_BASE_MV + TH_STEP_MV * {7'h0, code};
		// Top two codes both give the maximum
		if (code >= TH_SAT_CODE) begin
			v = TH_MAX_MV;
		end
		return v;
	endfunction

endpackage

/* File: hw/flc_led_chan.sv */
// One LED channel: flash and torch sequencing with safety timers.
// Assumes tick is a one-cycle pulse every microsecond, same clock.
`timescale 1ns/100ps
module flc_led_chan (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic flash_req,
	input wire logic torch_req,
	input wire logic flash_style,
	input wire logic torch_style,
	input wire logic torch_timer_off,
	input wire logic [23:0] flash_limit,
	input wire logic [23:0] torch_limit,
	output logic flash_on,
	output logic torch_on
);
	typedef enum logic [1:0] {CH_IDLE, CH_FLASH, CH_TORCH} flc_chmode_e;
	typedef struct packed {
		flc_chmode_e mode;
		logic [23:0] cnt;
		logic flash_armed;
		logic torch_armed;
	} flc_chan_s;

	flc_chan_s s_r;
	flc_chan_s s_nxt;
	logic cnt_last;

	// ==========================================================
	// Sequencer
	always_comb begin
		s_nxt = s_r;
		cnt_last = 1'b0;
		// A trigger must drop before it can start the LED again, except torch after flash preempts it
		if (!flash_req) begin
			s_nxt.flash_armed = 1'b1;
		end
		if (!torch_req) begin
			s_nxt.torch_armed = 1'b1;
		end
		if (tick) begin
			s_nxt.cnt = s_r.cnt + 24'h1;
		end
		unique case (s_r.mode)
			CH_IDLE: begin
				s_nxt.cnt = 24'h0;
				// [R10] Flash first
				if (flash_req && s_r.flash_armed) begin
					s_nxt.mode = CH_FLASH;
					s_nxt.flash_armed = 1'b0;
				end else if (torch_req && s_r.torch_armed) begin
					s_nxt.mode = CH_TORCH;
					s_nxt.torch_armed = 1'b0;
				end
			end
			CH_FLASH: begin
				cnt_last = tick && (s_r.cnt + 24'h1 >= flash_limit);
				// [R17] Timer ends flash
				// [R7] Style picks release
				if (cnt_last || (!flash_style && !flash_req)) begin
					s_nxt.mode = CH_IDLE;
				end
			end
			CH_TORCH: begin
				cnt_last = !torch_timer_off && tick && (s_r.cnt + 24'h1 >= torch_limit);
				if (flash_req && s_r.flash_armed) begin
					// [R10] Flash preempts torch
					s_nxt.mode = CH_FLASH;
					s_nxt.cnt = 24'h0;
					s_nxt.flash_armed = 1'b0;
					s_nxt.torch_armed = 1'b1;
				end else if (cnt_last) begin
					// [R17] Timer ends torch
					s_nxt.mode = CH_IDLE;
				end else if (!torch_req && (!torch_style || torch_timer_off)) begin
					// [R4] Untimed torch follows trigger
					// [R5] Style picks release
					s_nxt.mode = CH_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_r <= '{mode: CH_IDLE, cnt: 24'h0, flash_armed: 1'b1, torch_armed: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			flash_on <= 1'b0;
			torch_on <= 1'b0;
		end else begin
			flash_on <= (s_nxt.mode == CH_FLASH);
			torch_on <= (s_nxt.mode == CH_TORCH);
		end
	end
endmodule

/* File: hw/flc_lowbat.sv */
// Low-battery throttle detector with falling and rising mask timers.
// Assumes batt_mv is a digitised battery level in mV on this clock.
`timescale 1ns/100ps
module flc_lowbat (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic enable,
	input wire logic [4:0] threshold,
	input wire logic [1:0] hysteresis,
	input wire logic [2:0] fall_sel,
	input wire logic [2:0] rise_sel,
	input wire logic [11:0] batt_mv,
	output logic throttle
);
	typedef struct packed {
		logic throttled;
		logic [11:0] cnt;
	} flc_lowbat_s;

	flc_lowbat_s s_r;
	flc_lowbat_s s_nxt;
	logic [11:0] th_mv;
	logic [11:0] hys_mv;

	always_comb begin
		s_nxt = s_r;
		// [R12] Threshold from code
		th_mv = flc_pkg::thresh_mv(threshold);
		// [R13] Hysteresis steps
		hys_mv = flc_pkg::HYS_STEP_MV * ({10'h0, hysteresis} + 12'h1);
		if (!enable) begin
			// [R11] Throttle off
			s_nxt.throttled = 1'b0;
			s_nxt.cnt = 12'h0;
		end else if (!s_r.throttled) begin
			if (batt_mv < th_mv) begin
				if (tick) begin
					s_nxt.cnt = s_r.cnt + 12'h1;
				end
				// [R14] Falling mask
				// [R18] Lower after mask
				if (tick && (s_r.cnt + 12'h1 >= flc_pkg::mask_limit_us(fall_sel))) begin
					s_nxt.throttled = 1'b1;
					s_nxt.cnt = 12'h0;
				end
			end else begin
				s_nxt.cnt = 12'h0;
			end
		end else if (hysteresis != flc_pkg::HYS_NONE && batt_mv > th_mv + hys_mv) begin
			// [R13] No restore without hysteresis
			if (tick) begin
				s_nxt.cnt = s_r.cnt + 12'h1;
			end
			// [R15] Rising mask
			// [R18] Restore after mask
			if (tick && (s_r.cnt + 12'h1 >= flc_pkg::mask_limit_us(rise_sel))) begin
				s_nxt.throttled = 1'b0;
				s_nxt.cnt = 12'h0;
			end
		end else begin
			s_nxt.cnt = 12'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_r <= '{throttled: 1'b0, cnt: 12'h0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign throttle = s_r.throttled;
endmodule

/* File: bench/flc_props.sv */
// Port checker for flc_top.
// Assumes it is bound to flc_top and sees only its ports.
`timescale 1ns/100ps
module flc_props (
	input wire logic clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire logic flash_trigger_pin,
	input wire logic torch_trigger_pin,
	input wire logic [4:0] flash_code_a,
	input wire logic [11:0] batt_mv,
	input wire logic chan_a_flash_on,
	input wire logic chan_a_torch_on,
	input wire logic [5:0] chan_a_level,
	input wire logic chan_b_flash_on,
	input wire logic chan_b_torch_on,
	input wire logic battery_throttle
);
	logic [7:0] low_cnt;

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// ==========================================================
	// Helper
	// Cycles below the highest threshold; no mask is shorter than 256
	always_ff @(posedge clk) begin
		if (!resetn || batt_mv >= 12'hd48) begin
			low_cnt <= 8'h00;
		end else if (low_cnt != 8'hff) begin
			low_cnt <= low_cnt + 8'h01;
		end
	end

	// ==========================================================
	// Assertions
	rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	rd_cause_a: assert property (reg_rd_valid |-> $past(reg_rd_en))
		else $error("read answer without request");
	rdata_idle_a: assert property (!reg_rd_valid |-> reg_rdata == 8'h00)
		else $error("read data outside answer");
	trig_readback_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h05
		##1 !reg_wr_en ##1 reg_rd_en && !reg_wr_en && reg_addr == 8'h05
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("trigger select lost");
	prio_a_a: assert property (chan_a_flash_on |-> !chan_a_torch_on)
		else $error("channel a torch during flash");
	prio_b_a: assert property (chan_b_flash_on |-> !chan_b_torch_on)
		else $error("channel b torch during flash");
	flash_cause_a: assert property ($rose(chan_a_flash_on) |->
		$past(flash_trigger_pin, 4) || $past(torch_trigger_pin, 4) || $past(reg_wr_en, 3))
		else $error("flash started without trigger");
	flash_level_a: assert property (chan_a_flash_on && $past(chan_a_flash_on, 2)
		&& !battery_throttle && !$past(battery_throttle, 2) && $stable(flash_code_a)
		|-> chan_a_level == {flash_code_a, 1'b1}) else $error("flash level wrong");
	fall_mask_a: assert property ($rose(battery_throttle) |-> low_cnt == 8'hff)
		else $error("throttle before mask time");

	c_flash: cover property (chan_a_flash_on);
	c_torch: cover property (chan_a_torch_on);
	c_throttle: cover property ($fell(battery_throttle));
endmodule

bind flc_top flc_props u_props (.clk, .resetn, .reg_wr_en, .reg_rd_en, .reg_addr,
	.reg_wdata, .reg_rdata, .reg_rd_valid, .flash_trigger_pin, .torch_trigger_pin,
	.flash_code_a, .batt_mv, .chan_a_flash_on, .chan_a_torch_on, .chan_a_level,
	.chan_b_flash_on, .chan_b_torch_on, .battery_throttle);

/* File: bench/flc_host.sv */
// Host model: register strobes, trigger pins and battery level.
// Assumes the bench calls its tasks; drives at the falling edge.
`timescale 1ns/100ps
module flc_host (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic flash_trigger_pin,
	output logic torch_trigger_pin,
	output logic [11:0] batt_mv
);
	initial begin
		{reg_wr_en, reg_rd_en, flash_trigger_pin, torch_trigger_pin} = 4'h0;
		{reg_addr, reg_wdata} = 16'h0000;
		batt_mv = 12'hdac;
	end

	// ==========================================================
	// Bus cycles
	// Idle address and data inverted so stale values are never read
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		d = reg_rdata;
		v = reg_rd_valid;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
	endtask

	task automatic pins(input logic f, input logic t);
		@(negedge clk);
		flash_trigger_pin = f;
		torch_trigger_pin = t;
	endtask

	task automatic batt(input logic [11:0] mv);
		@(negedge clk);
		batt_mv = mv;
	endtask
endmodule

/* File: bench/flc_top_tb.sv */
// Self-checking bench for flc_top with the host model.
// Assumes one tick per clock so timers fit the run.
`timescale 1ns/100ps
module flc_top_tb;
	logic clk, resetn, wr_en, rd_en, rd_valid, fpin, tpin, throttle;
	logic a_fl, a_to, b_fl, b_to, v;
	logic [7:0] addr, wdata, rdata, d;
	logic [4:0] code_a, code_b;
	logic [5:0] lvl_a, lvl_b;
	logic [11:0] mv;
	int num_errors, compares, cycles;

	flc_top #(.TICK_CYCLES(1)) u_dut (.clk(clk), .resetn(resetn), .reg_wr_en(wr_en),
		.reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
		.reg_rd_valid(rd_valid), .flash_trigger_pin(fpin), .torch_trigger_pin(tpin),
		.flash_code_a(code_a), .flash_code_b(code_b), .batt_mv(mv),
		.chan_a_flash_on(a_fl), .chan_a_torch_on(a_to), .chan_a_level(lvl_a),
		.chan_b_flash_on(b_fl), .chan_b_torch_on(b_to), .chan_b_level(lvl_b),
		.battery_throttle(throttle));
	flc_host u_host (.clk(clk), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
		.reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
		.flash_trigger_pin(fpin), .torch_trigger_pin(tpin), .batt_mv(mv));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Run takes about 67100 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			num_errors++;
			stop_test();
		end
	end

	// ==========================================================
	// Helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, d, v);
		chk(d, exp);
		chk(8'(v), 8'h01);
	endtask

	task automatic wait_chk(input int n, input logic [7:0] got_sel, input logic [7:0] exp);
		repeat (n) @(negedge clk);
		chk(got_sel == 8'h00 ? 8'({a_fl, a_to, b_fl, b_to}) : 8'(throttle), exp);
	endtask

	task automatic stop_test;
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [7:0] m [6];
		m = '{8'h0f, 8'hcf, 8'h8f, 8'hff, 8'hff, 8'h3f};
		for (int i = 0; i < 6; i++) begin
			rchk(8'h02 + 8'(i), 8'h00);
			u_host.wr(8'h02 + 8'(i), 8'hff);
			rchk(8'h02 + 8'(i), m[i]);
			u_host.wr(8'h02 + 8'(i), 8'h00);
		end
		u_host.wr(8'h20, 8'h5a);
		rchk(8'h20, 8'h00);
	endtask

	task automatic t_prio;
		u_host.wr(flc_pkg::ADDR_TORCH_CUR, 8'h07);
		u_host.wr(flc_pkg::ADDR_TORCH_TIMEOUT_SETTING, 8'h40);
		u_host.wr(flc_pkg::ADDR_TRIG_SEL, 8'h49);
		u_host.pins(1'b1, 1'b1);
		wait_chk(6, 8'h00, 8'h09);
		chk(8'(lvl_a), 8'h15);
		u_host.pins(1'b0, 1'b1);
		wait_chk(6, 8'h00, 8'h04);
		chk(8'(lvl_a), 8'h07);
		u_host.pins(1'b0, 1'b0);
	endtask

	task automatic t_expire;
		u_host.wr(flc_pkg::ADDR_FLASH_TIMEOUT_SETTING, 8'h80);
		u_host.wr(flc_pkg::ADDR_TRIG_SEL, 8'h33);
		wait_chk(62000, 8'h00, 8'h02);
		chk(8'(lvl_b), 8'h05);
		wait_chk(1000, 8'h00, 8'h01);
		u_host.wr(flc_pkg::ADDR_TRIG_SEL, 8'h00);
	endtask

	task automatic t_throttle;
		u_host.wr(flc_pkg::ADDR_LOWBAT_T, 8'h08);
		u_host.wr(flc_pkg::ADDR_LOWBAT_V, 8'h84);
		u_host.batt(12'd2420);
		wait_chk(240, 8'h01, 8'h00);
		wait_chk(40, 8'h01, 8'h01);
		u_host.batt(12'd2500);
		wait_chk(600, 8'h01, 8'h01);
		u_host.wr(flc_pkg::ADDR_FLASH_TIMEOUT_SETTING, 8'h00);
		u_host.wr(flc_pkg::ADDR_TRIG_SEL, 8'h30);
		wait_chk(1600, 8'h01, 8'h01);
		chk(8'(lvl_b), 8'h00);
		u_host.wr(flc_pkg::ADDR_TRIG_SEL, 8'h00);
		rchk(flc_pkg::ADDR_STAT_B, 8'h80);
		u_host.batt(12'd2560);
		wait_chk(490, 8'h01, 8'h01);
		wait_chk(40, 8'h01, 8'h00);
		u_host.wr(flc_pkg::ADDR_LOWBAT_V, 8'h87);
		u_host.batt(12'd2420);
		wait_chk(300, 8'h01, 8'h01);
		u_host.batt(12'd3500);
		wait_chk(700, 8'h01, 8'h01);
	endtask

	initial begin
		resetn = 1'b0;
		code_a = 5'h0a;
		code_b = 5'h02;
		repeat (6) @(negedge clk);
		resetn = 1'b1;
		t_regs();
		t_prio();
		t_expire();
		t_throttle();
		stop_test();
	end
endmodule
